// ===== inc/gated_timer_map.svh
`ifndef GATED_TIMER_MAP_SVH
`define GATED_TIMER_MAP_SVH
// Register indices; byte address is four times the index
`define IDX_INT_CTL       10'h00b
`define IDX_PERIPH_FLAG   10'h00c
`define IDX_COUNT_LOW     10'h00e
`define IDX_COUNT_HIGH    10'h00f
`define IDX_TIMER_CTL     10'h010
`define IDX_CMP_CTL       10'h01a
`define IDX_PERIPH_EN     10'h08c
// Timer control fields
`define CTL_ON_BIT        0
`define CTL_CS_BIT        1
`define CTL_SYNC_BIT      2
`define CTL_LPO_BIT       3
`define CTL_PS_LSB        4
`define CTL_PS_MSB        5
`define CTL_GE_BIT        6
`define CTL_GINV_BIT      7
// Other register fields
`define FLAG_OVF_BIT      0
`define EN_OVF_BIT        0
`define INT_PERIPHERAL_INTERRUPT_ENABLE_BIT      6
`define INT_GIE_BIT       7
`define CMP_GSS_BIT       1
`define CMP_C2SYNC_BIT    0
// Reset values and the count limit
`define RST_TIMER_CTL     8'h00
`define RST_CMP_CTL       8'h02
`define RST_ZERO8         8'h00
`define RST_COUNT         16'h0000
`define COUNT_MAX         16'hffff
// System clocks per instruction cycle
`define CLK_PER_INSTR     4
`endif

// ===== inc/gated_timer_pkg.sv
package gated_timer_pkg;
  // Counting mode, one-hot
  typedef enum logic [2:0] {
    MODE_TIMER     = 3'b001,
    MODE_SYNC_CNT  = 3'b010,
    MODE_ASYNC_CNT = 3'b100
  } count_mode_t;
  typedef logic [7:0] byte_t;
endpackage

// ===== hw/timer_input_sync.sv
`timescale 1ns/10ps
`default_nettype none
// Three-stage pin synchroniser; a level is taken once stages two and three agree
module timer_input_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] level_o
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] level_nxt;

  // Refuse a chain with no bits at elaboration
  if (WIDTH < 1) begin : g_bad_width
    $error("timer_input_sync: WIDTH must be at least 1");
  end

  // Only stages two and three feed the agreement test
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      assign level_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : level_o[g];
    end
  endgenerate

  // Chain of three, then the agreed level
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s1_r    <= '0;
      s2_r    <= '0;
      s3_r    <= '0;
      level_o <= '0;
    end else if (ce_i) begin
      s1_r    <= pin_i;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      level_o <= level_nxt;
    end
  end
endmodule // timer_input_sync
`default_nettype wire

// ===== hw/timer_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
// Divides a tick stream by 1, 2, 4 or 8
module timer_prescaler (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       clear_i,
  input  wire logic       tick_i,
  input  wire logic [1:0] sel_i,
  output logic            pulse_o
);
  logic [2:0] cnt_r;
  logic [2:0] mask;
  logic       last;

  // Low bits that must all be set before a tick passes
  assign mask = (sel_i == 2'h0) ? 3'h0 :
                (sel_i == 2'h1) ? 3'h1 :
                (sel_i == 2'h2) ? 3'h3 : 3'h7;
  assign last = ((cnt_r & mask) == mask);

  // Clear wins over a tick so a count write restarts the division
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt_r   <= 3'h0;
      pulse_o <= 1'b0;
    end else if (ce_i) begin
      pulse_o <= tick_i & last & ~clear_i;
      if (clear_i) begin
        cnt_r <= 3'h0;
      end else if (tick_i) begin
        cnt_r <= last ? 3'h0 : cnt_r + 3'h1;
      end
    end
  end
endmodule // timer_prescaler
`default_nettype wire

// ===== hw/gated_sixteen_bit_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "gated_timer_map.svh"

module gated_sixteen_bit_timer
  import gated_timer_pkg::*;
#(
  parameter int PADDR_W       = 12,
  parameter int CLK_PER_INSTR = `CLK_PER_INSTR
) (
  input  wire logic               clk_sys_i,
  input  wire logic               rst_i,
  input  wire logic               ce_i,
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [PADDR_W-1:0] paddr_i,
  input  wire logic [31:0]        pwdata_i,
  output logic      [31:0]        prdata_o,
  output logic                    pready_o,
  output logic                    pslverr_o,
  input  wire logic               external_count_input_i,
  input  wire logic               gate_input_pin_i,
  input  wire logic               second_comparator_output_i,
  input  wire logic               low_power_oscillator_i,
  input  wire logic               internal_oscillator_no_clkout_i,
  input  wire logic               sleep_i,
  output logic                    irq_o,
  output logic                    wake_o
);
  localparam int PH_W = (CLK_PER_INSTR > 1) ? $clog2(CLK_PER_INSTR) : 1;
  localparam logic [PH_W-1:0] PH_LAST = PH_W'(CLK_PER_INSTR - 1);

  // Elaboration checks: the decode needs 12 address bits
  if (PADDR_W < 12) begin : g_bad_addr
    $error("gated_sixteen_bit_timer: PADDR_W below 12");
  end
  if (CLK_PER_INSTR < 1) begin : g_bad_rate
    $error("gated_sixteen_bit_timer: bad CLK_PER_INSTR");
  end

  // Register state
  byte_t       ctl_r;
  byte_t       cmp_ctl_r;
  logic        flag_r;
  logic        ovf_en_r;
  logic        peripheral_interrupt_enable_r;
  logic        gie_r;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        flag_nxt;
  logic [PH_W-1:0] phase_r;
  logic        src_prev_r;
  logic        armed_r;
  logic [31:0] rdata_nxt;
  logic        hit_nxt;

  // Synchronised pins: count input, gate pin, comparator, oscillator
  logic [3:0] pins_sync;
  timer_input_sync #(
    .WIDTH (4)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .pin_i     ({low_power_oscillator_i, second_comparator_output_i,
                 gate_input_pin_i, external_count_input_i}),
    .level_o   (pins_sync)
  );

  // Control field decode
  wire       tmr_on   = ctl_r[`CTL_ON_BIT];
  wire       cs_ext   = ctl_r[`CTL_CS_BIT];
  wire       no_sync  = ctl_r[`CTL_SYNC_BIT];
  wire       lpo_en   = ctl_r[`CTL_LPO_BIT];
  wire [1:0] ps_sel   = ctl_r[`CTL_PS_MSB:`CTL_PS_LSB];
  wire       gate_en  = ctl_r[`CTL_GE_BIT];
  wire       gate_inv = ctl_r[`CTL_GINV_BIT];
  wire       gss      = cmp_ctl_r[`CMP_GSS_BIT];

  // Mode from source and sync bits; sync bit ignored on internal clock
  count_mode_t mode;
  assign mode = !cs_ext ? MODE_TIMER :
                (no_sync ? MODE_ASYNC_CNT : MODE_SYNC_CNT);

  // Low-power oscillator replaces the pin only when the core allows it
  wire use_lpo = lpo_en & internal_oscillator_no_clkout_i;
  wire ext_src = use_lpo ? pins_sync[3] : pins_sync[0];

  // Edge detection on the selected external source
  wire ext_rise = ext_src & ~src_prev_r;
  wire ext_fall = ~ext_src & src_prev_r;

  // Instruction cycle tick from the system clock
  wire instr_tick = (phase_r == PH_LAST);

  // Gate: source, polarity, then enable; ignored while off
  wire gate_sig    = gss ? pins_sync[2] : pins_sync[1];
  wire gate_active = gate_inv ? gate_sig : ~gate_sig;
  wire gate_ok     = ~gate_en | gate_active;

  // Only asynchronous counting survives sleep
  wire awake_ok = ~sleep_i | (mode == MODE_ASYNC_CNT);
  wire count_ok = tmr_on & gate_ok & awake_ok;

  // Raw counting clock per mode
  logic raw_tick;
  always_comb begin
    raw_tick = 1'b0;
    unique case (mode)
      MODE_TIMER:     raw_tick = instr_tick;
      MODE_SYNC_CNT,
      MODE_ASYNC_CNT: raw_tick = ext_rise & armed_r;
    endcase
  end

  // APB decode
  wire [9:0] widx      = paddr_i[11:2];
  wire       setup     = psel_i & ~penable_i;
  wire       access_wr = psel_i & penable_i & pready_o & pwrite_i;
  wire       sel_int   = (widx == `IDX_INT_CTL);
  wire       sel_flag  = (widx == `IDX_PERIPH_FLAG);
  wire       sel_low   = (widx == `IDX_COUNT_LOW);
  wire       sel_high  = (widx == `IDX_COUNT_HIGH);
  wire       sel_ctl   = (widx == `IDX_TIMER_CTL);
  wire       sel_cmp   = (widx == `IDX_CMP_CTL);
  wire       sel_en    = (widx == `IDX_PERIPH_EN);
  wire       mapped    = sel_int | sel_flag | sel_low | sel_high |
                         sel_ctl | sel_cmp | sel_en;
  wire       wr_low    = access_wr & sel_low;
  wire       wr_high   = access_wr & sel_high;
  wire       wr_count  = wr_low | wr_high;

  // Prescaler, cleared by any count byte write
  logic ps_pulse;
  timer_prescaler u_ps (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .clear_i   (wr_count),
    .tick_i    (raw_tick & count_ok),
    .sel_i     (ps_sel),
    .pulse_o   (ps_pulse)
  );

  // One increment per pulse; a byte write wins over the increment
  wire inc      = ps_pulse & ~wr_count;
  wire overflow = inc & (cnt_r == `COUNT_MAX);
  always_comb begin
    cnt_nxt = inc ? cnt_r + 16'h0001 : cnt_r;
    if (wr_low) begin
      cnt_nxt[7:0] = pwdata_i[7:0];
    end
    if (wr_high) begin
      cnt_nxt[15:8] = pwdata_i[7:0];
    end
  end

  // Overflow set beats a software clear in the same cycle
  assign flag_nxt = overflow |
                    ((access_wr & sel_flag) ? pwdata_i[`FLAG_OVF_BIT] : flag_r);

  // Read mux; unused bits read zero
  assign rdata_nxt =
      sel_int  ? {24'h0, gie_r, peripheral_interrupt_enable_r, 6'h00} :
      sel_flag ? {31'h0, flag_r} :
      sel_low  ? {24'h0, cnt_r[7:0]} :
      sel_high ? {24'h0, cnt_r[15:8]} :
      sel_ctl  ? {24'h0, ctl_r} :
      sel_cmp  ? {24'h0, cmp_ctl_r} :
      sel_en   ? {31'h0, ovf_en_r} : 32'h0;
  assign hit_nxt = mapped;

  // Bus answer: ready in the first access cycle, data captured at setup
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0;
    end else if (ce_i) begin
      pready_o  <= setup;
      pslverr_o <= setup & ~hit_nxt;
      prdata_o  <= (setup & ~pwrite_i) ? rdata_nxt : 32'h0;
    end
  end

  // Software registers
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ctl_r     <= `RST_TIMER_CTL;
      cmp_ctl_r <= `RST_CMP_CTL;
      ovf_en_r  <= 1'b0;
      peripheral_interrupt_enable_r    <= 1'b0;
      gie_r     <= 1'b0;
    end else if (ce_i && access_wr) begin
      if (sel_ctl) ctl_r <= pwdata_i[7:0];
      if (sel_cmp) cmp_ctl_r <= {6'h00, pwdata_i[1:0]};
      if (sel_en)  ovf_en_r <= pwdata_i[`EN_OVF_BIT];
      if (sel_int) begin
        peripheral_interrupt_enable_r <= pwdata_i[`INT_PERIPHERAL_INTERRUPT_ENABLE_BIT];
        gie_r  <= pwdata_i[`INT_GIE_BIT];
      end
    end
  end

  // Counter, flag and phase
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt_r   <= `RST_COUNT;
      flag_r  <= 1'b0;
      phase_r <= '0;
    end else if (ce_i) begin
      cnt_r   <= cnt_nxt;
      flag_r  <= flag_nxt;
      phase_r <= instr_tick ? '0 : phase_r + PH_W'(1);
    end
  end

  // Arming: cleared while the timer is off or on the internal clock, so each start
  // needs a fresh falling edge before its first rising edge counts
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      src_prev_r <= 1'b0;
      armed_r    <= 1'b0;
    end else if (ce_i) begin
      src_prev_r <= ext_src;
      if (!(tmr_on && cs_ext)) begin
        armed_r <= 1'b0;
      end else if (ext_fall) begin
        armed_r <= 1'b1;
      end
    end
  end

  // Interrupt request and sleep wake, both registered
  wire irq_nxt  = flag_r & ovf_en_r & peripheral_interrupt_enable_r & gie_r;
  wire wake_nxt = overflow & sleep_i & ovf_en_r & peripheral_interrupt_enable_r &
                  (mode == MODE_ASYNC_CNT);
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      irq_o  <= 1'b0;
      wake_o <= 1'b0;
    end else if (ce_i) begin
      irq_o  <= irq_nxt;
      wake_o <= wake_nxt;
    end
  end

  // Checks
  sequence wrap_seq;
    ce_i && inc && cnt_r == 16'hffff;
  endsequence

  wrap_sets_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wrap_seq |=> flag_r && cnt_r == 16'h0000)
    else $error("wrap did not set flag or zero count");

  flag_holds_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (flag_r && !(access_wr && sel_flag)) |=> flag_r)
    else $error("overflow flag dropped without a clear");

  irq_needs_all_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    irq_o |-> $past(flag_r && ovf_en_r && peripheral_interrupt_enable_r && gie_r))
    else $error("interrupt raised without all enables");

  low_write_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (ce_i && wr_low) |=> cnt_r[7:0] == $past(pwdata_i[7:0]))
    else $error("low count byte write lost");

  stop_holds_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (!tmr_on && !wr_count) [*3] |-> $stable(cnt_r))
    else $error("count moved while timer off");

  unarmed_still_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (ce_i && mode != MODE_TIMER && !armed_r) |=> !ps_pulse)
    else $error("counted an edge before a falling edge");

  timer_rate_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (CLK_PER_INSTR > 1 && ce_i && raw_tick && mode == MODE_TIMER)
    |=> !raw_tick)
    else $error("timer ticks faster than instruction rate");

  gate_block_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (tmr_on && gate_en && !gate_active && ce_i) |=> !ps_pulse)
    else $error("counted while gate not asserted");

  apb_ready_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (ce_i && setup) |=> pready_o)
    else $error("no ready in first access cycle");

  sleep_stop_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (ce_i && sleep_i && mode != MODE_ASYNC_CNT) |=> !ps_pulse)
    else $error("synchronous count advanced in sleep");
endmodule // gated_sixteen_bit_timer
`default_nettype wire

// ===== tb/timer_source_model.sv
`timescale 1ns/10ps
`default_nettype none
// Far-side sources: count pin, low-power oscillator, gate pin, comparator
module timer_source_model #(
  parameter int HALF = 8
) (
  input  wire logic clk_sys_i,
  output logic      ext_clk_o,
  output logic      lpo_o,
  output logic      gate_pin_o,
  output logic      cmp_out_o
);
  // Clocks idle low, so a first burst rises before it ever falls
  initial begin
    ext_clk_o  = 1'b0;
    lpo_o      = 1'b0;
    gate_pin_o = 1'b1;
    cmp_out_o  = 1'b1;
  end
  // Low then high phase; each outlasts the pin synchroniser
  task automatic pulses(input int n, input bit on_lpo);
    for (int i = 0; i < n; i++) begin
      repeat (HALF) @(posedge clk_sys_i);
      if (on_lpo) lpo_o <= 1'b0;
      else ext_clk_o <= 1'b0;
      repeat (HALF) @(posedge clk_sys_i);
      if (on_lpo) lpo_o <= 1'b1;
      else ext_clk_o <= 1'b1;
    end
  endtask
  // Gate levels change just after an edge
  task automatic set_gate(input bit pin, input bit cmp);
    @(posedge clk_sys_i);
    gate_pin_o <= pin;
    cmp_out_o  <= cmp;
  endtask
endmodule // timer_source_model
`default_nettype wire

// ===== tb/test_gated_sixteen_bit_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "gated_timer_map.svh"
module test_gated_sixteen_bit_timer;
  import gated_timer_pkg::*;
  localparam int LIMIT = 40000;
  // {cmp source, invert, gate on, pin, cmp, counts}
  localparam logic [5:0] GATE_CASES [5] =
    '{6'b101010, 6'b111111, 6'b001011, 6'b011010, 6'b000111};
  logic        clk_sys_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr     = 12'h000;
  logic [31:0] pwdata    = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, irq, wake, ext_clk, lpo, gate_pin, cmp_out;
  logic        sleep = 1'b0, osc_ok = 1'b0, wake_seen = 1'b0, err_v;
  byte_t       rd_v;
  int          n_mismatch = 0, n_compared = 0, cycles = 0;
  // 100 MHz system clock
  always #5 clk_sys_i = ~clk_sys_i;
  gated_sixteen_bit_timer #(.PADDR_W(12), .CLK_PER_INSTR(4)) dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(1'b1),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr),
    .external_count_input_i(ext_clk), .gate_input_pin_i(gate_pin),
    .second_comparator_output_i(cmp_out), .low_power_oscillator_i(lpo),
    .internal_oscillator_no_clkout_i(osc_ok), .sleep_i(sleep),
    .irq_o(irq), .wake_o(wake));
  timer_source_model src (
    .clk_sys_i(clk_sys_i), .ext_clk_o(ext_clk), .lpo_o(lpo),
    .gate_pin_o(gate_pin), .cmp_out_o(cmp_out));
  // Hang guard; wake lasts one cycle, so it is caught here
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (wake === 1'b1) wake_seen <= 1'b1;
    if (cycles == LIMIT) begin
      fail("timeout");
      report_and_stop();
    end
  end
  task automatic fail(input string msg);
    n_mismatch++;
    $display("Error at %0t: %s", $time, msg);
  endtask
  // Range compare; an unknown bit never passes
  task automatic chk(input logic [15:0] got, lo, hi, input string what);
    n_compared++;
    if ((^got) === 1'bx || got < lo || got > hi) fail(what);
  endtask
  // One APB transfer, held until pready is seen at a rising edge
  task automatic apb(input bit wr, input logic [9:0] idx, input byte_t wd);
    @(posedge clk_sys_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge clk_sys_i);
    penable <= 1'b1;
    // Ends on pready; only the global cycle limit ends a wait that hangs
    do begin
      @(posedge clk_sys_i);
    end while (pready !== 1'b1);
    rd_v  = prdata[7:0];
    err_v = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] idx, input byte_t d);
    apb(1'b1, idx, d);
  endtask
  task automatic rd(input logic [9:0] idx, input byte_t lo, hi,
                    input string what);
    apb(1'b0, idx, 8'h00);
    chk({8'h00, rd_v}, {8'h00, lo}, {8'h00, hi}, what);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // Each count write also clears the hidden prescaler
  task automatic zero_count;
    wr(`IDX_COUNT_LOW, 8'h00);
    wr(`IDX_COUNT_HIGH, 8'h00);
  endtask
  // Reset values, byte access and an unmapped word
  task automatic t_regs;
    rd(`IDX_TIMER_CTL, 8'h00, 8'h00, "ctl reset");
    rd(`IDX_CMP_CTL, 8'h02, 8'h02, "cmp reset");
    rd(`IDX_PERIPH_FLAG, 8'h00, 8'h00, "flag reset");
    wr(`IDX_COUNT_LOW, 8'h34);
    wr(`IDX_COUNT_HIGH, 8'h12);
    rd(`IDX_COUNT_LOW, 8'h34, 8'h34, "count low");
    rd(`IDX_COUNT_HIGH, 8'h12, 8'h12, "count high");
    wr(`IDX_TIMER_CTL, 8'hf4);
    rd(`IDX_TIMER_CTL, 8'hf4, 8'hf4, "ctl rw");
    wr(`IDX_TIMER_CTL, 8'h00);
    apb(1'b0, 10'h3ff, 8'h00);
    chk({15'h0, err_v}, 16'h1, 16'h1, "unmapped");
  endtask
  // Timer mode at every prescale; sync bit set on the last pass
  task automatic t_prescale;
    byte_t e;
    for (int ps = 0; ps < 4; ps++) begin
      e = 8'(64 >> ps);
      zero_count();
      wr(`IDX_TIMER_CTL, {2'b00, 2'(ps), ((ps == 3) ? 4'h5 : 4'h1)});
      idle(256);
      wr(`IDX_TIMER_CTL, 8'h00);
      idle(4);
      rd(`IDX_COUNT_LOW, e - 1, e + 1, "rate");
      idle(40);
      rd(`IDX_COUNT_LOW, rd_v, rd_v, "held off");
    end
  endtask
  // Wrap from one below the top value, then every mix of the three enables
  task automatic t_overflow;
    wr(`IDX_PERIPH_FLAG, 8'h00);
    wr(`IDX_COUNT_LOW, 8'hfe);
    wr(`IDX_COUNT_HIGH, 8'hff);
    wr(`IDX_TIMER_CTL, 8'h01);
    idle(40);
    wr(`IDX_TIMER_CTL, 8'h00);
    rd(`IDX_COUNT_HIGH, 8'h00, 8'h00, "carry wrap");
    idle(60);
    rd(`IDX_PERIPH_FLAG, 8'h01, 8'h01, "flag stays");
    for (int m = 0; m < 8; m++) begin
      wr(`IDX_PERIPH_EN, {7'h00, m[0]});
      wr(`IDX_INT_CTL, {m[2], m[1], 6'h00});
      idle(3);
      chk({15'h0, irq}, 16'(m == 7), 16'(m == 7), "irq");
    end
    wr(`IDX_PERIPH_FLAG, 8'h00);
    idle(3);
    chk({15'h0, irq}, 16'h0, 16'h0, "irq cleared");
    wr(`IDX_INT_CTL, 8'h00);
  endtask
  // Writes closer than one 1:8 period keep the prescaler from firing
  task automatic t_ps_clear;
    zero_count();
    wr(`IDX_TIMER_CTL, 8'h31);
    repeat (10) begin
      idle(20);
      wr(`IDX_COUNT_HIGH, 8'h00);
    end
    wr(`IDX_TIMER_CTL, 8'h00);
    rd(`IDX_COUNT_LOW, 8'h00, 8'h00, "ps cleared");
  endtask
  // Pin idles low: the first rise precedes any fall and is not counted
  task automatic t_counter;
    zero_count();
    wr(`IDX_TIMER_CTL, 8'h03);
    src.pulses(4, 1'b0);
    idle(20);
    wr(`IDX_TIMER_CTL, 8'h00);
    rd(`IDX_COUNT_LOW, 8'h03, 8'h03, "armed");
  endtask
  // Oscillator source only counts while it is permitted
  task automatic t_lpo;
    zero_count();
    wr(`IDX_TIMER_CTL, 8'h0b);
    src.pulses(3, 1'b1);
    idle(20);
    rd(`IDX_COUNT_LOW, 8'h00, 8'h00, "lpo barred");
    osc_ok <= 1'b1;
    src.pulses(3, 1'b1);
    idle(20);
    wr(`IDX_TIMER_CTL, 8'h00);
    rd(`IDX_COUNT_LOW, 8'h02, 8'h03, "lpo count");
    osc_ok <= 1'b0;
  endtask
  // Gate source, polarity and enable; a low gate is the active level unless inverted
  task automatic t_gate;
    logic [5:0] g;
    for (int i = 0; i < 5; i++) begin
      g = GATE_CASES[i];
      src.set_gate(g[2], g[1]);
      wr(`IDX_CMP_CTL, {6'h00, g[5], 1'b0});
      zero_count();
      wr(`IDX_TIMER_CTL, {g[4], g[3], 6'h01});
      idle(80);
      wr(`IDX_TIMER_CTL, 8'h00);
      rd(`IDX_COUNT_LOW, g[0] ? 8'd17 : 8'd0, g[0] ? 8'd23 : 8'd0,
         "gate");
    end
  endtask
  // Asynchronous mode runs in sleep and wakes on wrap; sync mode halts
  task automatic t_sleep;
    // Wake needs overflow and peripheral enables; global stays off
    wr(`IDX_PERIPH_EN, 8'h01);
    wr(`IDX_INT_CTL, 8'h40);
    wr(`IDX_COUNT_LOW, 8'hff);
    wr(`IDX_COUNT_HIGH, 8'hff);
    sleep     <= 1'b1;
    wake_seen <= 1'b0;
    wr(`IDX_TIMER_CTL, 8'h07);
    src.pulses(2, 1'b0);
    idle(20);
    chk({15'h0, wake_seen}, 16'h1, 16'h1, "wake");
    wr(`IDX_TIMER_CTL, 8'h03);
    src.pulses(2, 1'b0);
    idle(20);
    wr(`IDX_TIMER_CTL, 8'h00);
    rd(`IDX_COUNT_LOW, 8'h01, 8'h01, "sleep count");
    rd(`IDX_COUNT_HIGH, 8'h00, 8'h00, "sleep wrap");
    wr(`IDX_INT_CTL, 8'h00);
    sleep <= 1'b0;
  endtask
  task automatic report_and_stop;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    idle(12);
    rst_i <= 1'b0;
    t_regs();
    t_prescale();
    t_overflow();
    t_ps_clear();
    t_counter();
    t_lpo();
    t_gate();
    t_sleep();
    report_and_stop();
  end
endmodule // test_gated_sixteen_bit_timer
`default_nettype wire
